/* File: rtl/pfl_consts.svh */
// register indices, flag bit positions, reset values and field layout
`ifndef PFL_CONSTS_SVH
`define PFL_CONSTS_SVH
// printed register indices; byte address is four times the index
`define PFL_IDX_FLAGS     8'h04
`define PFL_IDX_IRQ_CTRL  8'h05
`define PFL_IDX_CMD       8'h08
`define PFL_IDX_ACC_PTR   8'h09
`define PFL_IDX_ACC_VAL   8'h0A
`define PFL_FLAGS_RESET   8'h80
`define PFL_ACC_RESET     16'h0000
`define PFL_BIT_MATCH     0
`define PFL_BIT_CARRY     1
`define PFL_BIT_WRAP      2
`define PFL_BIT_SPARE_A   3
`define PFL_BIT_SPARE_B   4
`define PFL_BIT_RSVD      5
`define PFL_BIT_SIGN      6
`define PFL_BIT_ZERO      7
`define PFL_CMD_OP_LSB    0
`define PFL_CMD_OP_MSB    2
`define PFL_CMD_ARG_LSB   16
`define PFL_CMD_ARG_MSB   31
`define PFL_PTR_MSB       1
`endif

/* File: rtl/pfl_pkg.sv */
// types shared by the flags block modules
`default_nettype none
package pfl_pkg;
  typedef enum logic [2:0] {
    PFL_OP_NOP = 3'h0,
    PFL_OP_ADD = 3'h1,
    PFL_OP_SUB = 3'h2,
    PFL_OP_AND = 3'h3,
    PFL_OP_OR  = 3'h4,
    PFL_OP_XOR = 3'h5,
    PFL_OP_CMP = 3'h6
  } pfl_op_t;

  typedef struct packed {
    logic zero;
    logic sign;
    logic rsvd;
    logic spare_flag_b;
    logic spare_flag_a;
    logic signed_wrap_flag;
    logic carry;
    logic match;
  } pfl_flags_t;

  typedef enum logic [0:0] {
    PFL_APB_IDLE   = 1'b0,
    PFL_APB_ACCESS = 1'b1
  } pfl_apb_st_t;
endpackage
`default_nettype wire

/* File: rtl/pfl_dp_if.sv */
// datapath carrier between controller, alu and accumulator bank
`timescale 1ns/1ps
`default_nettype none
interface pfl_dp_if #(parameter int ACC_W = 16, parameter int PTR_W = 2);
  pfl_pkg::pfl_op_t   op;
  logic [ACC_W-1:0]   operand;
  logic [ACC_W-1:0]   result;
  logic               carry;
  logic               wrap;
  logic               equal;
  logic               wr_acc;
  logic               upd_carry;
  logic               upd_wrap;
  logic               upd_match;
  logic               wr_en;
  logic [PTR_W-1:0]   wr_ptr;
  logic [ACC_W-1:0]   wr_data;
  logic [PTR_W-1:0]   cur_ptr;
  logic [ACC_W-1:0]   cur_data;
  logic [PTR_W-1:0]   peek_ptr;
  logic [ACC_W-1:0]   peek_data;
  modport alu (input op, operand, cur_data,
               output result, carry, wrap, equal, wr_acc, upd_carry, upd_wrap, upd_match);
  modport bank (input wr_en, wr_ptr, wr_data, cur_ptr, peek_ptr, output cur_data, peek_data);
  modport ctl (output op, operand, wr_en, wr_ptr, wr_data, cur_ptr, peek_ptr,
               input result, carry, wrap, equal, wr_acc, upd_carry, upd_wrap, upd_match,
               input cur_data, peek_data);
endinterface
`default_nettype wire

/* File: rtl/pfl_alu.sv */
// arithmetic and logic unit on the active accumulator
`timescale 1ns/1ps
`default_nettype none
module pfl_alu (
  pfl_dp_if.alu dp
);
  logic [16:0] sum17;
  // partial sum of the low 15 bits: its top bit is the carry out of bit 14
  logic [15:0] low16;
  always_comb begin
    sum17        = 17'h00000;
    low16        = 16'h0000;
    dp.result    = dp.cur_data;
    dp.carry     = 1'b0;
    dp.wrap      = 1'b0;
    dp.equal     = 1'b0;
    dp.wr_acc    = 1'b0;
    dp.upd_carry = 1'b0;
    dp.upd_wrap  = 1'b0;
    dp.upd_match = 1'b0;
    case (dp.op)
      pfl_pkg::PFL_OP_ADD, pfl_pkg::PFL_OP_SUB: begin
        if (dp.op == pfl_pkg::PFL_OP_ADD) begin
          sum17 = {1'b0, dp.cur_data} + {1'b0, dp.operand};
          low16 = {1'b0, dp.cur_data[14:0]} + {1'b0, dp.operand[14:0]};
        end else begin
          sum17 = {1'b0, dp.cur_data} - {1'b0, dp.operand};
          low16 = {1'b0, dp.cur_data[14:0]} - {1'b0, dp.operand[14:0]};
        end
        dp.result    = sum17[15:0];
        dp.carry     = sum17[16]; // [RULE_05]
        dp.wrap      = low16[15] ^ sum17[16]; // [RULE_07] [RULE_08]
        dp.wr_acc    = 1'b1;
        dp.upd_carry = 1'b1;
        dp.upd_wrap  = 1'b1;
      end
      pfl_pkg::PFL_OP_AND, pfl_pkg::PFL_OP_OR, pfl_pkg::PFL_OP_XOR: begin
        if (dp.op == pfl_pkg::PFL_OP_AND) dp.result = dp.cur_data & dp.operand;
        else if (dp.op == pfl_pkg::PFL_OP_OR) dp.result = dp.cur_data | dp.operand;
        else dp.result = dp.cur_data ^ dp.operand;
        // logic ops never carry, so the flag clears
        dp.wr_acc    = 1'b1;
        dp.upd_carry = 1'b1; // [RULE_05]
      end
      pfl_pkg::PFL_OP_CMP: begin
        dp.equal     = (dp.cur_data == dp.operand); // [RULE_03]
        dp.upd_match = 1'b1;
      end
      default: begin
        dp.result = dp.cur_data;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/pfl_acc_bank.sv */
// bank of accumulators with one write and two read ports
`timescale 1ns/1ps
`default_nettype none
module pfl_acc_bank #(
  parameter int ACC_W = 16,
  parameter int NUM   = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  pfl_dp_if.bank   dp
);
  typedef struct packed {
    logic [NUM-1:0][ACC_W-1:0] acc;
  } pfl_bank_st_t;

  pfl_bank_st_t q;
  pfl_bank_st_t d;

  always_comb begin
    d = q;
    if (dp.wr_en) begin
      d.acc[dp.wr_ptr] = dp.wr_data; // [RULE_15]
    end
  end

  assign dp.cur_data  = q.acc[dp.cur_ptr]; // [RULE_14]
  assign dp.peek_data = q.acc[dp.peek_ptr];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pfl_top.sv */
// processor status flags block with accumulators behind an APB slave
//
// Overview of operation
// RULE_01: every reset loads the flags register with 80h, zero flag only set.
// RULE_02: flags readable; writes touch only wrap, match, carry, spare flags.
// RULE_03: match bit takes compare equality: 1 when equal, 0 when different.
// RULE_04: software writing 1 to match bit sets it like an equal compare.
// RULE_05: carry follows latest arithmetic or logic operation's carry or borrow.
// RULE_06: software writing 1 to carry bit sets it like a carrying operation.
// RULE_07: add sets wrap flag when exactly one of bits 14, 15 carries out.
// RULE_08: subtract sets wrap flag when borrow reaches exactly one of bits 14, 15.
// RULE_09: software can read and write the wrap flag to restore it.
// RULE_10: bits 3 and 4 store software values; operations never change them.
// RULE_11: bit 5 is reserved and always reads zero.
// RULE_12: sign flag mirrors active accumulator top bit, also on pointer switch.
// RULE_13: zero flag is NOR of active accumulator, also on pointer switch.
// RULE_14: active accumulator is one of four, chosen by two-bit pointer.
// RULE_15: accumulators are 16 bits; flags update on the result's write edge.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pfl_consts.svh"
module pfl_top #(
  parameter int ACC_W  = 16,
  parameter int NUM    = 4,
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [7:0]        processor_flags
);
  localparam int PTR_W = $clog2(NUM);

  typedef struct packed {
    pfl_pkg::pfl_apb_st_t st;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    pfl_pkg::pfl_flags_t  flags;
    logic [PTR_W-1:0]     ptr;
    pfl_pkg::pfl_op_t     op;
    logic [ACC_W-1:0]     operand;
  } pfl_top_st_t;

  // one-hot register select: {acc value, acc pointer, command, flags}
  typedef logic [3:0] pfl_sel_t;

  pfl_top_st_t q;
  pfl_top_st_t d;

  pfl_dp_if #(.ACC_W(ACC_W), .PTR_W(PTR_W)) dp ();

  pfl_alu u_alu (
    .dp (dp)
  );

  pfl_acc_bank #(.ACC_W(ACC_W), .NUM(NUM)) u_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .dp      (dp)
  );

  // misaligned or unknown words select nothing and answer with an error
  function automatic pfl_sel_t pfl_decode(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    pfl_sel_t   s;
    idx = a[9:2];
    s   = 4'h0;
    if (a[1:0] == 2'h0 && a[ADDR_W-1:10] == '0) begin
      case (idx)
        `PFL_IDX_FLAGS:   s = 4'h1;
        `PFL_IDX_CMD:     s = 4'h2;
        `PFL_IDX_ACC_PTR: s = 4'h4;
        `PFL_IDX_ACC_VAL: s = 4'h8;
        default:          s = 4'h0;
      endcase
    end
    return s;
  endfunction

  pfl_sel_t         sel;
  logic             access_fire;
  logic             wr_fire;
  logic             cmd_fire;
  logic             ptr_fire;
  logic             val_fire;
  logic             flags_fire;
  logic [ACC_W-1:0] next_active;
  logic [31:0]      rd_word;

  assign sel         = pfl_decode(paddr);
  assign access_fire = (q.st == pfl_pkg::PFL_APB_ACCESS) && psel && penable;
  assign wr_fire     = access_fire && pwrite && (sel != 4'h0);
  assign flags_fire  = wr_fire && sel[0];
  assign cmd_fire    = wr_fire && sel[1];
  assign ptr_fire    = wr_fire && sel[2];
  assign val_fire    = wr_fire && sel[3];

  // a command word runs its operation on the very edge that accepts it
  assign dp.op      = cmd_fire ? pfl_pkg::pfl_op_t'(pwdata[`PFL_CMD_OP_MSB:`PFL_CMD_OP_LSB])
                               : pfl_pkg::PFL_OP_NOP;
  assign dp.operand = pwdata[`PFL_CMD_ARG_MSB:`PFL_CMD_ARG_LSB];
  assign dp.cur_ptr = q.ptr; // [RULE_14]

  assign dp.wr_en   = val_fire || (cmd_fire && dp.wr_acc);
  assign dp.wr_ptr  = q.ptr;
  assign dp.wr_data = val_fire ? pwdata[ACC_W-1:0] : dp.result;

  // look ahead to the accumulator that is active after this edge
  assign dp.peek_ptr = ptr_fire ? pwdata[PTR_W-1:0] : q.ptr;
  assign next_active = (dp.wr_en && dp.wr_ptr == dp.peek_ptr) ? dp.wr_data : dp.peek_data;

  always_comb begin
    rd_word = 32'h00000000;
    case (sel)
      4'h1:    rd_word = {24'h000000, q.flags};
      4'h2:    rd_word = {q.operand, 13'h0000, q.op};
      4'h4:    rd_word = {{(32-PTR_W){1'b0}}, q.ptr};
      4'h8:    rd_word = {{(32-ACC_W){1'b0}}, dp.cur_data};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_comb begin
    d = q;
    case (q.st)
      pfl_pkg::PFL_APB_IDLE: begin
        // setup phase: the answer is prepared so pready can come from a flop
        if (psel && !penable) begin
          d.st      = pfl_pkg::PFL_APB_ACCESS;
          d.pready  = 1'b1;
          d.pslverr = (sel == 4'h0);
          d.prdata  = pwrite ? 32'h00000000 : rd_word;
        end
      end
      pfl_pkg::PFL_APB_ACCESS: begin
        d.st      = pfl_pkg::PFL_APB_IDLE;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        d.prdata  = 32'h00000000;
      end
      default: begin
        d.st      = pfl_pkg::PFL_APB_IDLE;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        d.prdata  = 32'h00000000;
      end
    endcase

    if (flags_fire) begin
      // sign, zero and reserved are not writable; they are recomputed below
      d.flags.match            = pwdata[`PFL_BIT_MATCH];    // [RULE_02] [RULE_04]
      d.flags.carry            = pwdata[`PFL_BIT_CARRY];    // [RULE_06]
      d.flags.signed_wrap_flag = pwdata[`PFL_BIT_WRAP];     // [RULE_09]
      d.flags.spare_flag_a     = pwdata[`PFL_BIT_SPARE_A];  // [RULE_10]
      d.flags.spare_flag_b     = pwdata[`PFL_BIT_SPARE_B];  // [RULE_10]
    end
    if (cmd_fire) begin
      d.op      = dp.op;
      d.operand = dp.operand;
      if (dp.upd_match) d.flags.match = dp.equal;                    // [RULE_03]
      if (dp.upd_carry) d.flags.carry = dp.carry;                    // [RULE_05] [RULE_15]
      if (dp.upd_wrap)  d.flags.signed_wrap_flag = dp.wrap;          // [RULE_07] [RULE_08]
    end
    if (ptr_fire) begin
      d.ptr = pwdata[PTR_W-1:0]; // [RULE_14]
    end
    // sign and zero follow whatever the active accumulator holds after this edge
    d.flags.sign = next_active[ACC_W-1]; // [RULE_12] [RULE_15]
    d.flags.zero = ~|next_active;        // [RULE_13] [RULE_15]
    d.flags.rsvd = 1'b0;                 // [RULE_11]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.st      <= pfl_pkg::PFL_APB_IDLE;
      q.pready  <= 1'b0;
      q.pslverr <= 1'b0;
      q.prdata  <= 32'h00000000;
      q.flags   <= pfl_pkg::pfl_flags_t'(`PFL_FLAGS_RESET); // [RULE_01]
      q.ptr     <= '0;
      q.op      <= pfl_pkg::PFL_OP_NOP;
      q.operand <= `PFL_ACC_RESET;
    end else begin
      q <= d;
    end
  end

  assign prdata          = q.prdata;
  assign pready          = q.pready;
  assign pslverr         = q.pslverr;
  assign processor_flags = q.flags;

  // helper values captured for the checks below
  logic [ACC_W-1:0] chk_a;
  logic [ACC_W-1:0] chk_b;
  logic [16:0]      chk_sum;
  logic [16:0]      chk_dif;
  assign chk_a   = dp.cur_data;
  assign chk_b   = dp.operand;
  assign chk_sum = {1'b0, chk_a} + {1'b0, chk_b};
  assign chk_dif = {1'b0, chk_a} - {1'b0, chk_b};

  a_reset_value: // [RULE_01]
  assert property (@(posedge pclk) $rose(presetn) |-> processor_flags == `PFL_FLAGS_RESET)
    else $error("flags not at reset value after reset release");

  a_sz_write_ignored: // [RULE_02]
  assert property (@(posedge pclk) disable iff (!presetn)
    flags_fire |=> $stable(processor_flags[`PFL_BIT_SIGN])
                   && $stable(processor_flags[`PFL_BIT_ZERO]))
    else $error("flags write changed sign or zero");

  a_match_compare: // [RULE_03]
  assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_fire && dp.op == pfl_pkg::PFL_OP_CMP)
      |=> processor_flags[`PFL_BIT_MATCH] == ($past(chk_a) == $past(chk_b)))
    else $error("match flag disagrees with compare");

  a_match_sw_set: // [RULE_04]
  assert property (@(posedge pclk) disable iff (!presetn)
    (flags_fire && pwdata[`PFL_BIT_MATCH]) |=> processor_flags[`PFL_BIT_MATCH])
    else $error("software write of one did not set match");

  a_carry_add: // [RULE_05]
  assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_fire && dp.op == pfl_pkg::PFL_OP_ADD)
      |=> processor_flags[`PFL_BIT_CARRY] == $past(chk_sum[16]))
    else $error("carry flag wrong after add");

  a_carry_logic: // [RULE_05]
  assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_fire && dp.op inside {pfl_pkg::PFL_OP_AND, pfl_pkg::PFL_OP_OR, pfl_pkg::PFL_OP_XOR})
      |=> !processor_flags[`PFL_BIT_CARRY])
    else $error("carry flag set after logic operation");

  a_carry_sw_set: // [RULE_06]
  assert property (@(posedge pclk) disable iff (!presetn)
    (flags_fire && pwdata[`PFL_BIT_CARRY]) |=> processor_flags[`PFL_BIT_CARRY])
    else $error("software write of one did not set carry");

  a_wrap_add: // [RULE_07]
  assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_fire && dp.op == pfl_pkg::PFL_OP_ADD)
      |=> processor_flags[`PFL_BIT_WRAP]
          == $past((chk_a[15] == chk_b[15]) && (chk_sum[15] != chk_a[15])))
    else $error("wrap flag wrong after add");

  a_wrap_sub: // [RULE_08]
  assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_fire && dp.op == pfl_pkg::PFL_OP_SUB)
      |=> processor_flags[`PFL_BIT_WRAP]
          == $past((chk_a[15] != chk_b[15]) && (chk_dif[15] != chk_a[15])))
    else $error("wrap flag wrong after subtract");

  a_wrap_restore: // [RULE_09]
  assert property (@(posedge pclk) disable iff (!presetn)
    flags_fire |=> processor_flags[`PFL_BIT_WRAP] == $past(pwdata[`PFL_BIT_WRAP]))
    else $error("wrap flag not restored by write");

  a_spare_hold: // [RULE_10]
  assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_fire || val_fire || ptr_fire) && !flags_fire
      |=> $stable(processor_flags[`PFL_BIT_SPARE_B:`PFL_BIT_SPARE_A]))
    else $error("spare flags changed by an operation");

  a_rsvd_zero: // [RULE_11]
  assert property (@(posedge pclk) disable iff (!presetn)
    !processor_flags[`PFL_BIT_RSVD] && !(access_fire && !pwrite && sel[0] && prdata[5]))
    else $error("reserved bit is not zero");

  a_sign_mirror: // [RULE_12]
  assert property (@(posedge pclk) disable iff (!presetn)
    processor_flags[`PFL_BIT_SIGN] == dp.cur_data[ACC_W-1])
    else $error("sign flag does not mirror active accumulator");

  a_zero_mirror: // [RULE_13]
  assert property (@(posedge pclk) disable iff (!presetn)
    processor_flags[`PFL_BIT_ZERO] == (dp.cur_data == '0))
    else $error("zero flag does not match active accumulator");

  a_ptr_switch: // [RULE_14]
  assert property (@(posedge pclk) disable iff (!presetn)
    ptr_fire |=> q.ptr == $past(pwdata[PTR_W-1:0]) && dp.cur_data == $past(next_active))
    else $error("pointer switch did not select the accumulator");

  a_same_edge: // [RULE_15]
  assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_fire && dp.wr_acc) |=> dp.cur_data == $past(dp.result)
      && processor_flags[`PFL_BIT_ZERO] == ($past(dp.result) == '0))
    else $error("flags and result not written on the same edge");

  a_apb_answer:
  assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && q.st == pfl_pkg::PFL_APB_IDLE) |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

  a_slverr_map:
  assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && q.st == pfl_pkg::PFL_APB_IDLE) |=> pslverr == ($past(sel) == 4'h0))
    else $error("slave error does not match address decode");

  a_prdata_idle:
  assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h00000000)
    else $error("read data not cleared outside the access cycle");

  a_flags_readable: // [RULE_02]
  assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && q.st == pfl_pkg::PFL_APB_IDLE && !pwrite && sel == 4'h1)
      |=> prdata == {24'h000000, processor_flags})
    else $error("flags read does not return the flags register");

  a_match_clear: // [RULE_02]
  assert property (@(posedge pclk) disable iff (!presetn)
    (flags_fire && !pwdata[`PFL_BIT_MATCH]) |=> !processor_flags[`PFL_BIT_MATCH])
    else $error("software write of zero did not clear match");

  a_spare_store: // [RULE_10]
  assert property (@(posedge pclk) disable iff (!presetn)
    flags_fire |=> processor_flags[`PFL_BIT_SPARE_B:`PFL_BIT_SPARE_A]
                   == $past(pwdata[`PFL_BIT_SPARE_B:`PFL_BIT_SPARE_A]))
    else $error("spare flags did not store the written value");

  a_carry_sub: // [RULE_05]
  assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_fire && dp.op == pfl_pkg::PFL_OP_SUB)
      |=> processor_flags[`PFL_BIT_CARRY] == $past(chk_a < chk_b))
    else $error("borrow flag wrong after subtract");

  a_cmp_keeps: // [RULE_05]
  assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_fire && dp.op == pfl_pkg::PFL_OP_CMP)
      |=> $stable(processor_flags[`PFL_BIT_WRAP:`PFL_BIT_CARRY]))
    else $error("compare changed carry or wrap");

  a_logic_wrap: // [RULE_07]
  assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_fire && dp.op inside {pfl_pkg::PFL_OP_AND, pfl_pkg::PFL_OP_OR, pfl_pkg::PFL_OP_XOR})
      |=> $stable(processor_flags[`PFL_BIT_WRAP]))
    else $error("logic operation changed the wrap flag");

  a_ptr_hold: // [RULE_14]
  assert property (@(posedge pclk) disable iff (!presetn)
    !ptr_fire |=> $stable(q.ptr))
    else $error("accumulator pointer moved without a write");
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the processor flags block over apb
`timescale 1ns/1ps
`default_nettype none
`include "pfl_consts.svh"
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  processor_flags;
  int          error_cnt;
  int          samples_checked;
  logic [31:0] seed;
  logic [15:0] acc_m [4];
  logic [1:0]  ptr_m;
  logic [4:0]  low_m;
  logic [31:0] cmd_m;
  logic [31:0] rd;
  logic        err;
  logic [2:0]  t_op [13] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2,
                             3'h6, 3'h6, 3'h3, 3'h5};
  logic [15:0] t_a  [13] = '{16'h7FFF, 16'hFFFF, 16'h8000, 16'h4000, 16'hC000, 16'h8000,
                             16'h0000, 16'h7FFF, 16'h0005, 16'h1234, 16'h1234, 16'hF0F0,
                             16'hAAAA};
  logic [15:0] t_b  [13] = '{16'h0001, 16'h0001, 16'h8000, 16'h4000, 16'h4000, 16'h0001,
                             16'h0001, 16'hFFFF, 16'h0005, 16'h1234, 16'h1235, 16'h0F0F,
                             16'hAAAA};

  pfl_top DUT (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .processor_flags (processor_flags)
  );

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] exp_flags();
    return {~|acc_m[ptr_m], acc_m[ptr_m][15], 1'b0, low_m};
  endfunction

  function automatic logic mapped(input logic [7:0] idx);
    return idx inside {`PFL_IDX_FLAGS, `PFL_IDX_CMD, `PFL_IDX_ACC_PTR, `PFL_IDX_ACC_VAL};
  endfunction

  function automatic logic [31:0] exp_read(input logic [7:0] idx);
    case (idx)
      `PFL_IDX_FLAGS:   return {24'h0, exp_flags()};
      `PFL_IDX_CMD:     return cmd_m;
      `PFL_IDX_ACC_PTR: return {30'h0, ptr_m};
      `PFL_IDX_ACC_VAL: return {16'h0, acc_m[ptr_m]};
      default:          return 32'h0;
    endcase
  endfunction

  task automatic note(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    note(g === e, $sformatf("flags %h exp %h", g, e));
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    note(g === e, $sformatf("read %h exp %h", g, e));
  endtask
  task automatic chk1(input logic g, input logic e);
    note(g === e, $sformatf("slverr %b exp %b", g, e));
  endtask

  // hazard: the result edge updates flags, so the model mirrors it before fin checks
  task automatic model_op(input logic [2:0] op, input logic [15:0] b);
    logic [15:0] a;
    logic [15:0] t;
    logic [16:0] s;
    a = acc_m[ptr_m];
    case (op)
      3'h1: begin
        t = {1'b0, a[14:0]} + {1'b0, b[14:0]};
        s = {1'b0, a} + {1'b0, b};
        acc_m[ptr_m] = s[15:0];
        low_m[2:1] = {t[15] ^ s[16], s[16]};
      end
      3'h2: begin
        t = {1'b0, a[14:0]} - {1'b0, b[14:0]};
        s = {1'b0, a} - {1'b0, b};
        acc_m[ptr_m] = s[15:0];
        low_m[2:1] = {t[15] ^ s[16], s[16]};
      end
      3'h3: {acc_m[ptr_m], low_m[1]} = {a & b, 1'b0};
      3'h4: {acc_m[ptr_m], low_m[1]} = {a | b, 1'b0};
      3'h5: {acc_m[ptr_m], low_m[1]} = {a ^ b, 1'b0};
      3'h6: low_m[0] = (a == b);
      default: ;
    endcase
  endtask

  // leaves the request standing at the access edge; caller releases or chains
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // the answer is taken at the rising edge, before the slave's flops move
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready === 1'b1) begin
      rd  = prdata;
      err = pslverr;
    end else begin
      note(1'b0, "no ready");
      print_verdict();
    end
  endtask

  task automatic fin();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
    chk8(processor_flags, exp_flags());
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d);
    case (idx)
      `PFL_IDX_FLAGS:   low_m = d[4:0];
      `PFL_IDX_CMD:     {cmd_m, low_m} = {d[31:16], 13'h0, d[2:0], low_m};
      `PFL_IDX_ACC_PTR: ptr_m = d[1:0];
      `PFL_IDX_ACC_VAL: acc_m[ptr_m] = d[15:0];
      default: ;
    endcase
    if (idx == `PFL_IDX_CMD) model_op(d[2:0], d[31:16]);
    fin();
    chk1(err, ~mapped(idx));
  endtask

  task automatic rdck(input logic [7:0] idx);
    logic [31:0] e;
    e = exp_read(idx);
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
    fin();
    chk32(rd, e);
    chk1(err, ~mapped(idx));
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    acc_m = '{default: 16'h0000};
    {ptr_m, low_m} = '0;
    cmd_m = 32'h0;
    @(negedge pclk);
    chk8(processor_flags, `PFL_FLAGS_RESET);
    @(posedge pclk);
  endtask

  initial begin
    #500000;
    note(1'b0, "watchdog expired");
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    {error_cnt, samples_checked} = '0;
    seed = 32'h73768543;
    cmd_m = 32'h0;
    do_reset();
    rdck(`PFL_IDX_FLAGS);
    wr(`PFL_IDX_FLAGS, 32'hFFFF_FFFF);
    rdck(`PFL_IDX_FLAGS);
    wr(`PFL_IDX_FLAGS, 32'h0000_0018);
    for (int i = 0; i < 13; i++) begin
      wr(`PFL_IDX_ACC_VAL, {16'h0, t_a[i]});
      wr(`PFL_IDX_CMD, {t_b[i], 13'h0, t_op[i]});
    end
    for (int op = 0; op < 8; op++) wr(`PFL_IDX_CMD, {16'h8001, 13'h0, op[2:0]});
    for (int p = 0; p < 4; p++) begin
      wr(`PFL_IDX_ACC_PTR, p);
      wr(`PFL_IDX_ACC_VAL, {16'h0, 16'h8000 >> (p * 5)});
    end
    for (int p = 3; p >= 0; p--) begin
      wr(`PFL_IDX_ACC_PTR, p);
      rdck(`PFL_IDX_ACC_VAL);
    end
    // back to back: write then read with no idle cycle between
    apb(1'b1, {2'b00, `PFL_IDX_ACC_VAL, 2'b00}, 32'h0000_C3A5);
    acc_m[ptr_m] = 16'hC3A5;
    apb(1'b0, {2'b00, `PFL_IDX_ACC_VAL, 2'b00}, 32'h0);
    fin();
    chk32(rd, 32'h0000_C3A5);
    wr(`PFL_IDX_IRQ_CTRL, 32'hFF);
    rdck(`PFL_IDX_IRQ_CTRL);
    apb(1'b1, 12'h011, 32'h0000_0007);
    fin();
    chk1(err, 1'b1);
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      case (r[2:0])
        3'h0, 3'h1, 3'h2: wr(`PFL_IDX_CMD, {r[9] ? {16{r[10]}} ^ {r[11], 15'h0}
                                   : r[31:16], 13'h0, r[5:3]});
        3'h3: wr(`PFL_IDX_ACC_PTR, rnd());
        3'h4: wr(`PFL_IDX_ACC_VAL, rnd());
        3'h5: wr(`PFL_IDX_FLAGS, rnd());
        3'h6: rdck(r[15:8]);
        default: rdck(`PFL_IDX_FLAGS);
      endcase
    end
    wr(`PFL_IDX_FLAGS, 32'h1F);
    do_reset();
    rdck(`PFL_IDX_ACC_VAL);
    print_verdict();
  end
endmodule
`default_nettype wire
